// ===== grpsw_pkg.sv
package grpsw_pkg;
  // ==========================================
  // System register offsets
  localparam logic [6:0] BANK_SEL_ADDR = 7'h7D;
  localparam logic [6:0] ROW_SEL_ADDR = 7'h7E;
  localparam logic [6:0] FLAGS_ADDR = 7'h7F;
  // ==========================================
  // Field positions
  localparam int DECIMAL_BIT = 0;
  localparam int CMP_BIT = 3;
  localparam int CARRY_BIT = 2;
  localparam int ZERO_BIT = 1;
  localparam int IDXEN_BIT = 0;
  localparam logic [3:0] BANK_WR_MASK = 4'h3;
  // ==========================================
  // Reset values
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [3:0] ROW_RST = 4'h0;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  // ==========================================
  // ALU operation kinds presented by the core
  typedef enum logic [1:0] {
    GRPSW_OP_NONE = 2'h0,
    GRPSW_OP_ARITH = 2'h1,
    GRPSW_OP_ROTATE = 2'h3
  } grpsw_op_type;
endpackage

// ===== gen_reg_pointer_status_word.sv
`timescale 1ns/100ps
// Contract
// - Pointer is bank nibble plus row's upper three
// - Upper two bank bits always zero
// - Bank nibble selects bank, row bits select row
// - Any row 0-7 in banks 0-3 selectable
// - Row register bit 0 is decimal-mode flag
// - Status word: row bit 0 plus flags nibble
// - Five flags: decimal, compare, carry, zero, index
// - Index-enable flag gates data address modification
// - Zero flag reports zero result, compare-dependent
// - Carry set on carry or borrow, else cleared
// - Carry is rotate-right-through-carry shift bit
// - Compare flag set discards arithmetic result
// - Decimal flag one means binary arithmetic
// - Arithmetic on status word stores result there
// - Carry with zero result leaves zero stored
// - Fixed-zero bits ignore writes, read zero
module gen_reg_pointer_status_word (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkStopRst,
  input wire logic chipEnRst,
  input wire logic [6:0] regAddr,
  input wire logic [3:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [3:0] regRdData,
  input wire logic [1:0] aluOp,
  input wire logic aluCarry,
  input wire logic aluZero,
  input wire logic [3:0] aluResult,
  input wire logic [6:0] aluDest,
  input wire logic rotOutBit,
  output logic [1:0] genRegBank,
  output logic [2:0] genRegRow,
  output logic indexEnable,
  output logic storeResult,
  output logic binaryMode,
  output logic carryFlag,
  output logic [4:0] programStatusWord
);
  logic rstMeta_r;
  logic rstSync_r;
  logic [3:0] bankSel_r;
  logic [3:0] rowSel_r;
  logic [3:0] flags_r;
  logic [3:0] bankSel_nxt;
  logic [3:0] rowSel_nxt;
  logic [3:0] flags_nxt;
  logic softClear;
  logic arithOp;
  logic rotOp;
  logic cmpSet;
  logic [3:0] rdMux;

  // ==========================================
  // Helpers
  // Bank bits 3:2 are hard zero on every path in and out
  function automatic logic [3:0] bankMask(input logic [3:0] raw);
    bankMask = raw & grpsw_pkg::BANK_WR_MASK;
  endfunction

  // ==========================================
  // Reset release
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // Clock-stop and chip-enable resets come from core logic on this clock
  assign softClear = clkStopRst | chipEnRst;
  assign arithOp = (aluOp == grpsw_pkg::GRPSW_OP_ARITH);
  assign rotOp = (aluOp == grpsw_pkg::GRPSW_OP_ROTATE);
  assign cmpSet = flags_r[grpsw_pkg::CMP_BIT];

  // ==========================================
  // Next-state logic
  always_comb
  begin
    bankSel_nxt = bankSel_r;
    rowSel_nxt = rowSel_r;
    flags_nxt = flags_r;
    if (regWrEn)
    begin
      case (regAddr)
        grpsw_pkg::BANK_SEL_ADDR: bankSel_nxt = bankMask(regWrData);
        grpsw_pkg::ROW_SEL_ADDR: rowSel_nxt = regWrData;
        grpsw_pkg::FLAGS_ADDR: flags_nxt = regWrData;
        default: ;
      endcase
    end
    if (arithOp)
    begin
      if (aluDest == grpsw_pkg::FLAGS_ADDR && !cmpSet)
      begin
        // Result wins over flag updates, so carry+0000B leaves 0000B
        flags_nxt = aluResult;
      end
      else
      begin
        flags_nxt[grpsw_pkg::CARRY_BIT] = aluCarry;
        if (!cmpSet)
        begin
          flags_nxt[grpsw_pkg::ZERO_BIT] = aluZero;
        end
        else if (!aluZero)
        begin
          // Compare mode: zero is retained only while results stay zero
          flags_nxt[grpsw_pkg::ZERO_BIT] = 1'b0;
        end
        if (!cmpSet && aluDest == grpsw_pkg::ROW_SEL_ADDR)
        begin
          rowSel_nxt = aluResult;
        end
        if (!cmpSet && aluDest == grpsw_pkg::BANK_SEL_ADDR)
        begin
          bankSel_nxt = bankMask(aluResult);
        end
      end
    end
    else if (rotOp)
    begin
      flags_nxt[grpsw_pkg::CARRY_BIT] = rotOutBit;
    end
    // Sync clears beat writes and ALU, and reach the output copies too
    if (softClear)
    begin
      bankSel_nxt = grpsw_pkg::BANK_RST;
      rowSel_nxt = grpsw_pkg::ROW_RST;
      flags_nxt = grpsw_pkg::FLAGS_RST;
    end
  end

  // ==========================================
  // Register state
  always_ff @(posedge mclk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      bankSel_r <= grpsw_pkg::BANK_RST;
    end
    else if (softClear)
    begin
      bankSel_r <= grpsw_pkg::BANK_RST;
    end
    else
    begin
      bankSel_r <= bankSel_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      rowSel_r <= grpsw_pkg::ROW_RST;
    end
    else if (softClear)
    begin
      rowSel_r <= grpsw_pkg::ROW_RST;
    end
    else
    begin
      rowSel_r <= rowSel_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      flags_r <= grpsw_pkg::FLAGS_RST;
    end
    else if (softClear)
    begin
      flags_r <= grpsw_pkg::FLAGS_RST;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================
  // Read port, data one cycle after strobe
  always_comb
  begin
    case (regAddr)
      grpsw_pkg::BANK_SEL_ADDR: rdMux = bankMask(bankSel_r);
      grpsw_pkg::ROW_SEL_ADDR: rdMux = rowSel_r;
      grpsw_pkg::FLAGS_ADDR: rdMux = flags_r;
      default: rdMux = 4'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      regRdData <= 4'h0;
    end
    else
    begin
      regRdData <= regRdEn ? rdMux : 4'h0;
    end
  end

  // ==========================================
  // Pointer decode toward the core
  // Copies load from next-state so they match the registers each cycle
  always_ff @(posedge mclk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      genRegBank <= 2'h0;
    end
    else
    begin
      genRegBank <= bankSel_nxt[1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      genRegRow <= 3'h0;
    end
    else
    begin
      genRegRow <= rowSel_nxt[3:1];
    end
  end

  // ==========================================
  // Flag decode toward the core
  always_ff @(posedge mclk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      indexEnable <= 1'b0;
    end
    else
    begin
      indexEnable <= flags_nxt[grpsw_pkg::IDXEN_BIT];
    end
  end

  // Compare clear after reset, so results are stored
  always_ff @(posedge mclk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      storeResult <= 1'b1;
    end
    else
    begin
      storeResult <= ~flags_nxt[grpsw_pkg::CMP_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      binaryMode <= 1'b0;
    end
    else
    begin
      binaryMode <= rowSel_nxt[grpsw_pkg::DECIMAL_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      carryFlag <= 1'b0;
    end
    else
    begin
      carryFlag <= flags_nxt[grpsw_pkg::CARRY_BIT];
    end
  end

  // ==========================================
  // Status word copy
  always_ff @(posedge mclk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      programStatusWord <= 5'h00;
    end
    else
    begin
      programStatusWord <= {rowSel_nxt[grpsw_pkg::DECIMAL_BIT], flags_nxt};
    end
  end
endmodule // gen_reg_pointer_status_word

// ===== grpsw_props.sv
`timescale 1ns/100ps
// ====
// Checks
module grpsw_props (
  input logic mclk,
  input logic rst_b,
  input logic clkStopRst,
  input logic chipEnRst,
  input logic [6:0] regAddr,
  input logic [3:0] regWrData,
  input logic regWrEn,
  input logic [1:0] aluOp,
  input logic [3:0] aluResult,
  input logic [6:0] aluDest,
  input logic [1:0] genRegBank,
  input logic [2:0] genRegRow,
  input logic indexEnable,
  input logic storeResult,
  input logic binaryMode,
  input logic carryFlag,
  input logic [4:0] programStatusWord
);
  wire [4:0] s = programStatusWord;
  wire c = !clkStopRst && !chipEnRst;
  // ALU traffic wins on flags, so writes only count when it is quiet
  wire w = c && regWrEn && aluOp == 2'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_row; w && regAddr == 7'h7E |=> genRegRow == $past(regWrData[3:1]); endproperty
  a_row: assert property (p_row) else $error("row");
  property p_bank; w && regAddr == 7'h7D |=> genRegBank == $past(regWrData[1:0]); endproperty
  a_bank: assert property (p_bank) else $error("bank");
  property p_dec; binaryMode == s[4]; endproperty
  a_dec: assert property (p_dec) else $error("dec");
  property p_cmp; storeResult != s[3]; endproperty
  a_cmp: assert property (p_cmp) else $error("cmp");
  property p_ix; indexEnable == s[0]; endproperty
  a_ix: assert property (p_ix) else $error("ix");
  property p_cy; carryFlag == s[2]; endproperty
  a_cy: assert property (p_cy) else $error("cy");
  property p_clr; !c |=> s == 5'h00 && genRegBank == 2'h0; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_psw; c && aluOp == 2'h1 && storeResult && aluDest == 7'h7F
    |=> s[3:0] == $past(aluResult); endproperty
  a_psw: assert property (p_psw) else $error("psw");
endmodule // grpsw_props
bind gen_reg_pointer_status_word grpsw_props u_props (.*);

// ===== grpsw_core.sv
`timescale 1ns/100ps
// ====
// Core side
module grpsw_core (
  input logic mclk,
  output logic [1:0] aluOp,
  output logic aluCarry,
  output logic aluZero,
  output logic [3:0] aluResult,
  output logic [6:0] aluDest,
  output logic rotOutBit
);
  initial {aluOp, aluCarry, aluZero, aluResult, aluDest, rotOutBit} = '0;
  task run(input logic [1:0] o, input logic [3:0] r, input logic y, input logic [6:0] d);
    @(posedge mclk) {aluOp, aluResult, aluDest} <= {o, r, d};
    {aluCarry, aluZero, rotOutBit} <= {y, r == 4'h0, y};
    // Idle result, carry and rotate bit inverted so stale values never pass for fresh ones
    @(posedge mclk) {aluOp, aluResult, aluCarry, rotOutBit} <= {2'h0, ~r, ~y, ~y};
    #1;
  endtask
endmodule // grpsw_core

// ===== gen_reg_pointer_status_word_bench.sv
`timescale 1ns/100ps
// ====
// Bench
module gen_reg_pointer_status_word_bench;
  logic mclk, rst_b, clkStopRst, chipEnRst, regWrEn, regRdEn, aluCarry, aluZero, rotOutBit;
  logic indexEnable, storeResult, binaryMode, carryFlag;
  logic [6:0] regAddr, aluDest;
  logic [3:0] regWrData, regRdData, aluResult;
  logic [1:0] aluOp, genRegBank;
  logic [2:0] genRegRow;
  logic [4:0] programStatusWord;
  int errors = 0;
  int comparisons = 0;
  gen_reg_pointer_status_word dut (.*);
  grpsw_core core (.*);
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task chk(input string n, input logic [4:0] e, input logic [4:0] g);
    comparisons++;
    errors += int'(g !== e);
    if (g !== e) $display("MISMATCH %s exp %h got %h", n, e, g);
  endtask
  task wr(input logic [6:0] a, input logic [3:0] d);
    @(posedge mclk) {regWrEn, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge mclk) regWrEn <= 1'b0;
    #1;
  endtask
  task rd(input logic [6:0] a, input logic [3:0] e);
    @(posedge mclk) {regRdEn, regAddr} <= {1'b1, a};
    @(posedge mclk) regRdEn <= 1'b0;
    #1 chk("rdata", {1'b0, e}, {1'b0, regRdData});
  endtask
  task stop_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    {rst_b, clkStopRst, chipEnRst, regWrEn, regRdEn, regAddr, regWrData} = '0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int a = 13; a < 16; a++) rd({3'h7, a[3:0]}, 4'h0);
    wr(7'h7D, 4'hF);
    rd(7'h7D, 4'h3);
    rd(7'h10, 4'h0);
    for (int r = 0; r < 8; r++)
    begin
      wr(7'h7E, {r[2:0], r[0]});
      chk("row", {2'h0, r[2:0]}, {2'h0, genRegRow});
      chk("word", {r[0], 4'h0}, programStatusWord);
      chk("binary", {4'h0, r[0]}, {4'h0, binaryMode});
    end
    $display("T1 done");
    wr(7'h7F, 4'hA);
    chk("store", 5'h00, {4'h0, storeResult});
    core.run(2'h1, 4'h0, 1'b1, 7'h20);
    rd(7'h7F, 4'hE);
    core.run(2'h1, 4'h3, 1'b0, 7'h20);
    rd(7'h7F, 4'h8);
    wr(7'h7F, 4'h0);
    core.run(2'h1, 4'h0, 1'b1, 7'h7F);
    rd(7'h7F, 4'h0);
    core.run(2'h1, 4'h5, 1'b0, 7'h7F);
    rd(7'h7F, 4'h5);
    chk("index", 5'h01, {4'h0, indexEnable});
    core.run(2'h1, 4'h0, 1'b0, 7'h20);
    rd(7'h7F, 4'h3);
    core.run(2'h3, 4'h0, 1'b1, 7'h20);
    chk("carry", 5'h01, {4'h0, carryFlag});
    $display("T2 done");
    for (int i = 0; i < 2; i++)
    begin
      wr(7'h7D, 4'h3);
      @(posedge mclk) {chipEnRst, clkStopRst} <= {i[0], !i[0]};
      @(posedge mclk) {chipEnRst, clkStopRst} <= 2'h0;
      #1 chk("clear", 5'h00, programStatusWord | {3'h0, genRegBank});
    end
    $display("T3 done");
    stop_test();
  end
endmodule // gen_reg_pointer_status_word_bench
